// [design/ims_regs.svh]
// Constants for the two-wire master bus sequencer: timing, bit counts and field positions.
// Assumes a 125 MHz core clock and an instruction cycle of 121 ns.
`ifndef IMS_REGS_SVH
`define IMS_REGS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define IMS_CLK_PERIOD_PS 8000
`define IMS_TCY_PS 121000
// Rate counter steps twice per instruction cycle
`define IMS_HALF_TCY_PS (`IMS_TCY_PS / 2)
`define IMS_TICK_CYCLES ((`IMS_HALF_TCY_PS) / (`IMS_CLK_PERIOD_PS))

// ----------------------------------------------------------------------------
// Field positions and counts
// ----------------------------------------------------------------------------
`define IMS_RELOAD_MSB 6
`define IMS_BYTE_W 8
`define IMS_FIFO_DEPTH 8
`define IMS_LAST_DATA_BIT 4'h7
`define IMS_ACK_BIT 4'h8
`define IMS_SYNC_RESET 3'b111

`endif

// [design/ims_pkg.sv]
// Types shared by the two-wire master bus sequencer.
// Field layouts follow the lower five command bits and the sticky event flags.
package ims_pkg;

  typedef enum logic [4:0] {
    ST_IDLE,
    ST_S_WAIT, ST_S_HOLD,
    ST_R_SCLLOW, ST_R_SDAHI, ST_R_SCLREL, ST_R_HIGH, ST_R_SDALOW,
    ST_TX_LOW, ST_TX_REL, ST_TX_HIGH,
    ST_RX_LOW, ST_RX_REL, ST_RX_HIGH,
    ST_A_LOW, ST_A_REL, ST_A_HIGH
  } ims_state_t;

  // Lower five command bits, bit 4 first
  typedef struct packed {
    logic ack_sequence_enable;
    logic receive_enable;
    logic stop_request;
    logic restart_request;
    logic start_request;
  } ims_cmd_t;

  typedef struct packed {
    logic bus_collision_flag;
    logic serial_irq_flag;
    logic receive_overflow;
    logic write_collision;
    logic start_seen;
  } ims_flags_t;

endpackage

// [design/ims_sequencer.sv]
// Master bus condition sequencer (start, repeated start, transmit, receive, acknowledge)
// with a receive FIFO. Assumes open-drain pads outside and a processor-side
// controller that issues one-shot commands and byte writes as single-cycle pulses.
`timescale 1ns/1ps
`include "ims_regs.svh"

// ----------------------------------------------------------------------------
// Receive FIFO
// ----------------------------------------------------------------------------
module ims_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;

  // Extra pointer bit tells full from empty
  assign in_ready = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule

// ----------------------------------------------------------------------------
// Sequencer
// ----------------------------------------------------------------------------
// Summary of operation
// - Start request with both lines high reloads rate counter from reload value.
// - Lines still high at expiry: pull data low, set start-seen flag.
// - Reload again; at expiry clear start request, halt counter, keep data low.
// - Lines low at start or clock low before data drop: collision, idle.
// - Command writes are ignored while a start or repeated start runs.
// - Buffer write during any sequence is dropped and sets write collision.
// - Repeated start only from idle: pull clock low, then release data one period.
// - Expiry with data high releases clock; after high seen, wait, then data low.
// - End of repeated start: clear request, no reload, data low, flag after expiry.
// - Repeated start request while another event runs is ignored.
// - Repeated start collision: data low at clock rise, or clock falls early.
// - Buffer write in idle sets buffer full and starts shifting out.
// - Each bit: data after clock falls, clock low one period, high one period.
// - After eighth falling edge clear buffer full and release data.
// - Ninth falling edge samples data into acknowledge status.
// - After ninth clock raise event flag, halt counter, clock low, data free.
// - Receive enable only from idle; counter toggles clock, samples shift in.
// - After eighth received bit: clear enable, store byte, flags, clock low, idle.
// - Reading the last queued receive byte clears buffer full.
// - Byte completing while buffer full still set raises receive overflow.
// - Acknowledge: clock low, drive ack value, period, release, period, clock low.
// - Rate counter counts down to zero, stops, steps twice per instruction cycle.
// - After clock release the counter waits for clock high, then reloads.
module ims_sequencer
  import ims_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Configuration
  input wire logic [7:0] rate_reload,
  input wire logic ack_data_value,
  // Commands and buffer writes
  input wire logic cmd_write,
  input wire ims_cmd_t cmd_wdata,
  input wire logic buf_write,
  input wire logic [7:0] buf_wdata,
  input wire ims_flags_t flag_clear,
  // Received bytes
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  // Status
  output ims_cmd_t control_two,
  output ims_flags_t flags,
  output logic ack_status,
  output logic buffer_full,
  // Bus pins
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n
);
  ims_state_t state;
  logic [2:0] sda_sy;
  logic [2:0] scl_sy;
  logic sda_s;
  logic scl_s;
  logic [7:0] tick_div;
  logic tick;
  logic [6:0] brg_cnt;
  logic brg_run;
  logic brg_done;
  logic [6:0] reload_val;
  logic sda_drive;
  logic scl_drive;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic tx_full;
  logic rx_push;
  logic rx_room;
  logic collide;

  function automatic logic tx_bit_of(input logic [7:0] data, input logic [3:0] idx);
    return (idx > `IMS_LAST_DATA_BIT) ? 1'b1 : data[3'h7 - idx[2:0]];
  endfunction

  assign reload_val = rate_reload[`IMS_RELOAD_MSB:0];
  assign brg_done = brg_run && (brg_cnt == 7'h00);
  assign buffer_full = tx_full | rx_valid;
  // Open-drain: only ever pull low
  assign sda_out = 1'b0;
  assign scl_out = 1'b0;
  assign sda_oe_n = ~sda_drive;
  assign scl_oe_n = ~scl_drive;

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  // A level counts once the second and third stages agree, filtering glitches
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sda_sy <= `IMS_SYNC_RESET;
      scl_sy <= `IMS_SYNC_RESET;
      sda_s <= 1'b1;
      scl_s <= 1'b1;
    end else begin
      sda_sy <= {sda_sy[1:0], sda_in};
      scl_sy <= {scl_sy[1:0], scl_in};
      if (sda_sy[1] == sda_sy[2]) begin
        sda_s <= sda_sy[2];
      end
      if (scl_sy[1] == scl_sy[2]) begin
        scl_s <= scl_sy[2];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Half instruction cycle tick
  // --------------------------------------------------------------------------
  assign tick = tick_div == 8'h00;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      tick_div <= 8'h00;
    end else if (tick) begin
      tick_div <= 8'(`IMS_TICK_CYCLES - 1);
    end else begin
      tick_div <= tick_div - 8'h01;
    end
  end

  // --------------------------------------------------------------------------
  // Collision detection
  // --------------------------------------------------------------------------
  always_comb begin
    case (state)
      ST_S_WAIT: collide = !scl_s;
      ST_R_SDAHI: collide = brg_done && !sda_s;
      ST_R_SCLREL: collide = scl_s && !sda_s;
      ST_R_HIGH: collide = !scl_s;
      ST_TX_HIGH: collide = (bit_cnt != `IMS_ACK_BIT) && !sda_drive && !sda_s;
      ST_A_HIGH: collide = !sda_drive && !sda_s;
      default: collide = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------------
  // Sequencing, rate counter and status
  // --------------------------------------------------------------------------
  // Flags clear first, then any set in the same cycle overrides the clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= ST_IDLE;
      control_two <= '0;
      flags <= '0;
      ack_status <= 1'b0;
      tx_full <= 1'b0;
      sda_drive <= 1'b0;
      scl_drive <= 1'b0;
      brg_cnt <= 7'h00;
      brg_run <= 1'b0;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      rx_push <= 1'b0;
    end else begin
      flags <= flags & ~flag_clear;
      rx_push <= 1'b0;
      if (tick && brg_run && brg_cnt != 7'h00) begin
        brg_cnt <= brg_cnt - 7'h01;
      end
      if (buf_write && state != ST_IDLE) begin
        flags.write_collision <= 1'b1;
      end
      if (collide) begin
        // Abandon the sequence and let both lines float
        flags.bus_collision_flag <= 1'b1;
        control_two <= '0;
        tx_full <= 1'b0;
        sda_drive <= 1'b0;
        scl_drive <= 1'b0;
        brg_run <= 1'b0;
        state <= ST_IDLE;
      end else begin
        case (state)
          ST_IDLE: begin
            if (buf_write) begin
              shift <= buf_wdata;
              tx_full <= 1'b1;
              bit_cnt <= 4'h0;
              scl_drive <= 1'b1;
              brg_cnt <= reload_val;
              brg_run <= 1'b1;
              state <= ST_TX_LOW;
            end else if (cmd_write) begin
              if (cmd_wdata.start_request) begin
                if (sda_s && scl_s) begin
                  control_two.start_request <= 1'b1;
                  brg_cnt <= reload_val;
                  brg_run <= 1'b1;
                  state <= ST_S_WAIT;
                end else begin
                  flags.bus_collision_flag <= 1'b1;
                end
              end else if (cmd_wdata.restart_request) begin
                control_two.restart_request <= 1'b1;
                scl_drive <= 1'b1;
                state <= ST_R_SCLLOW;
              end else if (cmd_wdata.receive_enable && rx_room) begin
                // A full receive FIFO holds off a new byte
                control_two.receive_enable <= 1'b1;
                bit_cnt <= 4'h0;
                scl_drive <= 1'b1;
                sda_drive <= 1'b0;
                brg_cnt <= reload_val;
                brg_run <= 1'b1;
                state <= ST_RX_LOW;
              end else if (cmd_wdata.ack_sequence_enable) begin
                control_two.ack_sequence_enable <= 1'b1;
                scl_drive <= 1'b1;
                sda_drive <= ~ack_data_value;
                brg_cnt <= reload_val;
                brg_run <= 1'b1;
                state <= ST_A_LOW;
              end
            end
          end
          ST_S_WAIT: begin
            // Data pulled low by another master: assert early
            if (!sda_s || brg_done) begin
              sda_drive <= 1'b1;
              flags.start_seen <= 1'b1;
              brg_cnt <= reload_val;
              brg_run <= 1'b1;
              state <= ST_S_HOLD;
            end
          end
          ST_S_HOLD: begin
            if (brg_done) begin
              control_two.start_request <= 1'b0;
              brg_run <= 1'b0;
              flags.serial_irq_flag <= 1'b1;
              state <= ST_IDLE;
            end
          end
          ST_R_SCLLOW: begin
            if (!scl_s) begin
              sda_drive <= 1'b0;
              brg_cnt <= reload_val;
              brg_run <= 1'b1;
              state <= ST_R_SDAHI;
            end
          end
          ST_R_SDAHI: begin
            if (brg_done) begin
              scl_drive <= 1'b0;
              brg_run <= 1'b0;
              state <= ST_R_SCLREL;
            end
          end
          ST_R_SCLREL: begin
            if (scl_s) begin
              brg_cnt <= reload_val;
              brg_run <= 1'b1;
              state <= ST_R_HIGH;
            end
          end
          ST_R_HIGH: begin
            if (brg_done) begin
              sda_drive <= 1'b1;
              brg_cnt <= reload_val;
              brg_run <= 1'b1;
              state <= ST_R_SDALOW;
            end
          end
          ST_R_SDALOW: begin
            if (!sda_s && scl_s) begin
              flags.start_seen <= 1'b1;
            end
            if (brg_done) begin
              control_two.restart_request <= 1'b0;
              brg_run <= 1'b0;
              flags.serial_irq_flag <= 1'b1;
              state <= ST_IDLE;
            end
          end
          ST_TX_LOW: begin
            // Data only changes once the clock is seen low, keeping hold time
            if (!scl_s) begin
              sda_drive <= ~tx_bit_of(shift, bit_cnt);
            end
            if (brg_done) begin
              scl_drive <= 1'b0;
              brg_run <= 1'b0;
              state <= ST_TX_REL;
            end
          end
          ST_TX_REL: begin
            if (scl_s) begin
              brg_cnt <= reload_val;
              brg_run <= 1'b1;
              state <= ST_TX_HIGH;
            end
          end
          ST_TX_HIGH: begin
            if (brg_done) begin
              scl_drive <= 1'b1;
              if (bit_cnt == `IMS_ACK_BIT) begin
                ack_status <= sda_s;
                flags.serial_irq_flag <= 1'b1;
                brg_run <= 1'b0;
                state <= ST_IDLE;
              end else begin
                if (bit_cnt == `IMS_LAST_DATA_BIT) begin
                  tx_full <= 1'b0;
                end
                bit_cnt <= bit_cnt + 4'h1;
                brg_cnt <= reload_val;
                brg_run <= 1'b1;
                state <= ST_TX_LOW;
              end
            end
          end
          ST_RX_LOW: begin
            if (brg_done) begin
              scl_drive <= 1'b0;
              brg_run <= 1'b0;
              state <= ST_RX_REL;
            end
          end
          ST_RX_REL: begin
            if (scl_s) begin
              brg_cnt <= reload_val;
              brg_run <= 1'b1;
              state <= ST_RX_HIGH;
            end
          end
          ST_RX_HIGH: begin
            if (brg_done) begin
              shift <= {shift[6:0], sda_s};
              scl_drive <= 1'b1;
              if (bit_cnt == `IMS_LAST_DATA_BIT) begin
                rx_push <= 1'b1;
                control_two.receive_enable <= 1'b0;
                flags.serial_irq_flag <= 1'b1;
                if (buffer_full) begin
                  flags.receive_overflow <= 1'b1;
                end
                brg_run <= 1'b0;
                state <= ST_IDLE;
              end else begin
                bit_cnt <= bit_cnt + 4'h1;
                brg_cnt <= reload_val;
                brg_run <= 1'b1;
                state <= ST_RX_LOW;
              end
            end
          end
          ST_A_LOW: begin
            if (brg_done) begin
              scl_drive <= 1'b0;
              brg_run <= 1'b0;
              state <= ST_A_REL;
            end
          end
          ST_A_REL: begin
            if (scl_s) begin
              brg_cnt <= reload_val;
              brg_run <= 1'b1;
              state <= ST_A_HIGH;
            end
          end
          ST_A_HIGH: begin
            if (brg_done) begin
              scl_drive <= 1'b1;
              control_two.ack_sequence_enable <= 1'b0;
              flags.serial_irq_flag <= 1'b1;
              brg_run <= 1'b0;
              state <= ST_IDLE;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Reading a byte pops it, which clears buffer full when none remain
  ims_fifo #(
    .WIDTH(`IMS_BYTE_W),
    .DEPTH(`IMS_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(rx_push),
    .in_ready(rx_room),
    .in_data(shift),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence start_accept;
    state == ST_IDLE && !buf_write && cmd_write && cmd_wdata.start_request && sda_s && scl_s;
  endsequence

  sequence rx_last_bit;
    state == ST_RX_HIGH && !collide && brg_done && bit_cnt == `IMS_LAST_DATA_BIT;
  endsequence

  start_reload_a: assert property (start_accept |=>
    state == ST_S_WAIT && brg_run && brg_cnt == $past(reload_val))
    else $error("start did not reload rate counter");
  start_drive_a: assert property (state == ST_S_WAIT && !collide && brg_done |=>
    sda_drive && scl_s && flags.start_seen && state == ST_S_HOLD)
    else $error("start did not pull data low");
  start_done_a: assert property (state == ST_S_HOLD && brg_done |=>
    !control_two.start_request && !brg_run && sda_drive && state == ST_IDLE)
    else $error("start did not complete");
  start_coll_a: assert property (state == ST_S_WAIT && !scl_s |=>
    flags.bus_collision_flag && state == ST_IDLE && !sda_drive)
    else $error("start collision not flagged");
  cmd_lock_a: assert property (state inside {ST_S_WAIT, ST_S_HOLD, ST_R_HIGH} && cmd_write |=>
    !control_two.receive_enable && !control_two.ack_sequence_enable)
    else $error("command accepted during start");
  write_collision_keep_a: assert property (state inside {ST_S_WAIT, ST_S_HOLD} && buf_write |=>
    flags.write_collision && shift == $past(shift) && !tx_full)
    else $error("buffer write during start not refused");
  tx_start_a: assert property (state == ST_IDLE && buf_write |=>
    buffer_full && brg_run && state == ST_TX_LOW ##1 scl_drive)
    else $error("buffer write did not start transmit");
  ack_sample_a: assert property (state == ST_TX_HIGH && brg_done && bit_cnt == `IMS_ACK_BIT |=>
    ack_status == $past(sda_s) && flags.serial_irq_flag && scl_drive && !brg_run)
    else $error("acknowledge not sampled");
  rx_done_a: assert property (rx_last_bit |=>
    !control_two.receive_enable && state == ST_IDLE && scl_drive ##1 rx_valid)
    else $error("receive did not complete");
  stretch_a: assert property (state == ST_TX_REL && !scl_s |=>
    state == ST_TX_REL && !brg_run)
    else $error("counter ran while clock held low");
endmodule

// [tb/ims_slave_model.sv]
// Behavioural target on the far side of the two-wire bus.
// Assumes the bench wires it open-drain with pull-ups and clears it before each byte.
`timescale 1ns/1ps
module ims_slave_model (
  // Clock and control
  input wire logic clk,
  input wire logic clear,
  input wire logic rd_mode,
  input wire logic nack,
  input wire logic stretch,
  input wire logic [7:0] rd_byte,
  // Bus
  input wire logic scl,
  input wire logic sda,
  output logic sda_low,
  output logic scl_low
);
  logic scl_q;
  logic [3:0] rises;
  logic [4:0] hold;

  // Data changes only while the clock is low, never as a bus condition
  always @(posedge clk) begin
    scl_q <= scl;
    if (clear) begin
      rises <= 4'h0;
      hold <= 5'h00;
      sda_low <= 1'b0;
    end else begin
      if (scl && !scl_q) rises <= rises + 4'h1;
      if (!scl && scl_q && stretch) hold <= 5'h1f;
      else if (hold != 5'h00) hold <= hold - 5'h01;
      if (!scl && rd_mode) sda_low <= rises < 4'h8 && !rd_byte[3'h7 - rises[2:0]];
      else if (!scl) sda_low <= rises == 4'h8 && !nack;
    end
  end
  assign scl_low = hold != 5'h00;
endmodule

// [tb/tb.sv]
// Self-checking bench for the bus sequencer with a target model.
// Assumes the receive path returns bytes MSB first and pins are pulled up.
`timescale 1ns/1ps
module tb;
  import ims_pkg::*;
  logic clk = 0, resetn = 0, cmd_write = 0, buf_write = 0, rx_ready = 0, ack_data_value = 0;
  logic [7:0] rate_reload = 8'h02, buf_wdata = 8'h00, b0, b1;
  ims_cmd_t cmd_wdata = '0;
  ims_flags_t flag_clear = '0, flags;
  ims_cmd_t control_two;
  logic rx_valid, ack_status, buffer_full, sda_out, scl_out, sda_oe_n, scl_oe_n;
  logic [7:0] rx_data;
  logic sl_clr = 1, rd_mode = 0, nack = 0, stretch = 0, sl_sda, sl_scl, tb_scl = 0, scl_q;
  logic [8:0] mon;
  int n_errors = 0, checks = 0, seed = 32'h5ddc34fe;
  wire sda = sda_oe_n & ~sl_sda;
  wire scl = scl_oe_n & ~sl_scl & ~tb_scl;

  always #4 clk = ~clk;
  ims_sequencer dut (.clk(clk), .resetn(resetn), .rate_reload(rate_reload),
    .ack_data_value(ack_data_value), .cmd_write(cmd_write), .cmd_wdata(cmd_wdata),
    .buf_write(buf_write), .buf_wdata(buf_wdata), .flag_clear(flag_clear),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .control_two(control_two),
    .flags(flags), .ack_status(ack_status), .buffer_full(buffer_full), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .scl_in(scl), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n));
  ims_slave_model slave (.clk(clk), .clear(sl_clr), .rd_mode(rd_mode), .nack(nack),
    .stretch(stretch), .rd_byte(b0), .scl(scl), .sda(sda), .sda_low(sl_sda),
    .scl_low(sl_scl));

  // Data seen on the wire at each clock rise
  always @(posedge clk) begin
    scl_q <= scl;
    if (sl_clr) mon <= '0;
    else if (scl && !scl_q) mon <= {mon[7:0], sda};
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask
  task automatic test_done;
    if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmd(input ims_cmd_t c);
    @(negedge clk) cmd_write = 1;
    cmd_wdata = c;
    @(negedge clk) cmd_write = 0;
  endtask
  // Clears flags and the target, then lets one edge pass
  task automatic clr;
    @(negedge clk) flag_clear = '1;
    sl_clr = 1;
    @(negedge clk) flag_clear = '0;
    sl_clr = 0;
  endtask
  task automatic wait_on(input int bit_no);
    int i;
    for (i = 0; i < 20000 && flags[bit_no] !== 1'b1; i++) @(negedge clk);
    if (i == 20000) begin
      n_errors++;
      test_done();
    end
    repeat (2) @(negedge clk);
  endtask

  initial begin
    repeat (8) @(negedge clk);
    resetn = 1;
    rate_reload = 8'h02 + 8'($random(seed) & 7);
    repeat (3) @(negedge clk);
    chk("reset flags", 8'h00, 8'(flags));
    chk("reset pins", 8'h03, {6'h00, sda_oe_n, scl_oe_n});
    tb_scl = 1;
    cmd(5'h01);
    wait_on(4);
    chk("start collision cmd", 8'h00, 8'(control_two));
    clr();
    cmd(5'h01);
    chk("start refused", 8'h10, 8'(flags));
    tb_scl = 0;
    // Let the released clock line pass the pin synchroniser before the start
    repeat (4) @(negedge clk);
    clr();
    cmd(5'h01);
    chk("start cmd", 8'h01, 8'(control_two));
    @(negedge clk) buf_write = 1;
    @(negedge clk) buf_write = 0;
    cmd(5'h02);
    chk("cmd ignored", 8'h01, 8'(control_two));
    wait_on(3);
    chk("start flags", 8'h0b, 8'(flags));
    chk("start end", 8'h00, {2'h0, control_two, sda_oe_n});
    chk("dropped write", 8'h00, {7'h0, buffer_full});
    for (int k = 0; k < 2; k++) begin
      nack = k[0];
      buf_wdata = 8'($random(seed));
      clr();
      @(negedge clk) buf_write = 1;
      @(negedge clk) buf_write = 0;
      chk("tx full", 8'h01, {7'h0, buffer_full});
      wait_on(3);
      chk("tx byte", buf_wdata, mon[8:1]);
      chk("ack status", {7'h0, nack}, {7'h0, ack_status});
      chk("tx end", 8'h02, {5'h0, buffer_full, sda_oe_n, scl_oe_n});
    end
    rd_mode = 1;
    stretch = 1;
    b0 = 8'($random(seed));
    for (int k = 0; k < 2; k++) begin
      clr();
      cmd(5'h08);
      wait_on(3);
      chk("rx end", 8'h00, {2'h0, control_two, scl_oe_n});
      if (k == 0) b1 = b0;
      b0 = ~b0;
    end
    chk("rx overflow", 8'h01, {7'h0, flags.receive_overflow});
    chk("rx first", b1, rx_data);
    @(negedge clk) rx_ready = 1;
    @(negedge clk) rx_ready = 0;
    chk("rx second", ~b1, rx_data);
    @(negedge clk) rx_ready = 1;
    @(negedge clk) rx_ready = 0;
    chk("rx read", 8'h00, {7'h0, buffer_full});
    rd_mode = 0;
    stretch = 0;
    ack_data_value = 1;
    clr();
    cmd(5'h10);
    wait_on(3);
    chk("ack sent", 8'h01, {7'h0, mon[0]});
    chk("ack end", 8'h00, {2'h0, control_two, scl_oe_n});
    clr();
    cmd(5'h02);
    chk("restart cmd", 8'h02, 8'(control_two));
    wait_on(3);
    chk("restart seen", 8'h01, {7'h0, flags.start_seen});
    chk("restart end", 8'h00, {2'h0, control_two, sda_oe_n});
    chk("pins low only", 8'h00, {6'h0, sda_out, scl_out});
    test_done();
  end
endmodule
